// ===== verilog/csu_pkg.sv
// Purpose: Constants, register map and carrier types of the clock supervision unit.
// Assumes: APB register access with 32-bit data; offsets are byte addresses.
// Notes: Holds definitions only; the logic lives in the top module.
// Function
// - Two watchdogs: measurement clock and filter clock.
// - Count monitored edges in reference-clock timed window.
// - Too few edges in window raises fault output.
// - Frequency outside limits raises fault output.
// - Dedicated fault output toward processor NMI.
// - System clock loss forces switches and LIN off.
// - Programmable lower/upper limits with own hysteresis.
// - Measurement clock frequency, six bits, 0.75 MHz.
// - Filter clock frequency, six bits, 0.09375 MHz.
// - Enable bit powers watchdog down, resets to one.
// - Measurement clock limits and hysteresis in bits 15:0.
// - Filter clock limits and hysteresis in bits 31:16.
// - 26-bit tick calibration: noref, skew, reload.
// - Word-only access, offsets decoded as full byte addresses.
`default_nettype none
package csu_pkg;
	// Register byte offsets.
	localparam logic [11:0] CSU_OFF_FREQ_STS = 12'h000;
	localparam logic [11:0] CSU_OFF_CTRL = 12'h004;
	localparam logic [11:0] CSU_OFF_LIMITS = 12'h00c;
	localparam logic [11:0] CSU_OFF_IRQ_STS = 12'h010;
	localparam logic [11:0] CSU_OFF_IRQ_MASK = 12'h014;
	localparam logic [11:0] CSU_OFF_CALIB = 12'h06c;
	// Reset values.
	localparam logic [31:0] CSU_RST_CTRL = 32'h0000_0001;
	localparam logic [31:0] CSU_RST_LIMITS = 32'hd4e1_94b3;
	localparam logic [25:0] CSU_RST_CALIB = 26'h000_0000;
	// Field positions of the frequency status register.
	localparam int CSU_FS_MEAS_LSB = 0;
	localparam int CSU_FS_FILT_LSB = 8;
	// Field positions of the limit register.
	localparam int CSU_LIM_MEAS_UP = 0;
	localparam int CSU_LIM_MEAS_UP_HYS = 6;
	localparam int CSU_LIM_MEAS_LOW = 8;
	localparam int CSU_LIM_MEAS_LOW_HYS = 14;
	localparam int CSU_LIM_FILT_UP = 16;
	localparam int CSU_LIM_FILT_UP_HYS = 22;
	localparam int CSU_LIM_FILT_LOW = 24;
	localparam int CSU_LIM_FILT_LOW_HYS = 30;
	// Field positions of the calibration value.
	localparam int CSU_CAL_NOREF = 25;
	localparam int CSU_CAL_SKEW = 24;
	// Interrupt status and mask bit positions.
	localparam int CSU_IRQ_MEAS = 0;
	localparam int CSU_IRQ_FILT = 1;
	localparam int CSU_IRQ_LOSS = 2;
	// Widths of counters and fields.
	localparam int CSU_CNT_W = 16;
	localparam int CSU_FREQ_W = 6;
	localparam int CSU_IRQ_W = 3;
	localparam int CSU_CAL_W = 26;
	localparam logic [3:0] CSU_FULL_WORD = 4'hf;

	// APB request from the master.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} csu_apb_req_type;

	// APB answer to the master.
	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} csu_apb_rsp_type;

	// Switch-off commands toward the power stages.
	typedef struct packed {
		logic low_side_off;
		logic high_side_off;
		logic lin_off;
	} csu_shutdown_type;

	// Whole state of the supervision unit.
	typedef struct packed {
		logic [2:0] meas_sync;
		logic [2:0] filt_sync;
		logic [2:0] lp_sync;
		logic [2:0] sysf_sync;
		logic [CSU_CNT_W-1:0] lp_cnt;
		logic [CSU_CNT_W-1:0] meas_pre;
		logic [CSU_CNT_W-1:0] filt_pre;
		logic [CSU_FREQ_W-1:0] meas_cnt;
		logic [CSU_FREQ_W-1:0] filt_cnt;
		logic sysf_seen;
		logic [CSU_FREQ_W-1:0] meas_freq;
		logic [CSU_FREQ_W-1:0] filt_freq;
		logic meas_low;
		logic meas_high;
		logic filt_low;
		logic filt_high;
		logic clk_loss;
		logic enable;
		logic [31:0] limits;
		logic [CSU_CAL_W-1:0] calib;
		logic [CSU_IRQ_W-1:0] irq_sts;
		logic [CSU_IRQ_W-1:0] irq_mask;
		logic [31:0] prdata;
		logic pslverr;
	} csu_state_type;
endpackage : csu_pkg
`default_nettype wire

// ===== verilog/csu_top.sv
// Purpose: Clock supervision unit with two frequency watchdogs and system clock loss shutdown.
// Assumes: Monitored clocks and the reference clock arrive as pins, well below half of sys_clk_in.
// Notes: One frequency count equals DIV monitored edges per window of LP_WINDOW reference edges.
`timescale 1ns/1ns
`default_nettype none
module csu_top
	import csu_pkg::*;
#(
	parameter int LP_WINDOW = 16,
	parameter int MEAS_DIV = 1,
	parameter int FILT_DIV = 1
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire csu_apb_req_type apb_req_in,
	output csu_apb_rsp_type apb_rsp_out,
	input wire logic meas_clock_in,
	input wire logic filter_clock_in,
	input wire logic low_power_reference_clock_in,
	input wire logic system_freq_clock_in,
	output logic clock_fault_nmi_out,
	output logic irq_out,
	output csu_shutdown_type shutdown_out,
	output logic [CSU_CAL_W-1:0] tick_calibration_out
);

	// Refuse settings that the counters cannot hold.
	if (LP_WINDOW < 2 || LP_WINDOW >= (1 << CSU_CNT_W)) begin : g_bad_window
		$error("LP_WINDOW out of range");
	end
	if (MEAS_DIV < 1 || FILT_DIV < 1 || MEAS_DIV >= (1 << CSU_CNT_W) || FILT_DIV >= (1 << CSU_CNT_W)) begin : g_bad_div
		$error("Prescaler out of range");
	end

	localparam logic [CSU_CNT_W-1:0] WIN_LAST = CSU_CNT_W'(LP_WINDOW - 1);
	localparam logic [CSU_CNT_W-1:0] MEAS_LAST = CSU_CNT_W'(MEAS_DIV - 1);
	localparam logic [CSU_CNT_W-1:0] FILT_LAST = CSU_CNT_W'(FILT_DIV - 1);
	localparam logic [CSU_FREQ_W-1:0] FREQ_MAX = 6'h3f;

	// Reset image of the whole state.
	localparam csu_state_type STATE_RESET = '{
		enable: CSU_RST_CTRL[0],
		limits: CSU_RST_LIMITS,
		calib: CSU_RST_CALIB,
		default: '0
	};

	// Evaluates one out-of-range flag pair with hysteresis; returns {high, low}.
	function automatic logic [1:0] csu_range(
		input logic [CSU_FREQ_W-1:0] freq,
		input logic [CSU_FREQ_W-1:0] up,
		input logic [1:0] up_hys,
		input logic [CSU_FREQ_W-1:0] low,
		input logic [1:0] low_hys,
		input logic high_now,
		input logic low_now
	);
		logic hi;
		logic lo;
		hi = high_now;
		lo = low_now;
		// Below the lower limit means too few edges in the window.
		if (freq < low) begin
			lo = 1'b1;
		end else if ({1'b0, freq} >= ({1'b0, low} + {5'h00, low_hys})) begin
			lo = 1'b0;
		end
		// Above the upper limit is also a failure.
		if (freq > up) begin
			hi = 1'b1;
		end else if (({1'b0, freq} + {5'h00, up_hys}) <= {1'b0, up}) begin
			hi = 1'b0;
		end
		return {hi, lo};
	endfunction : csu_range

	csu_state_type s; // Registered state.
	csu_state_type next_s; // Next state.
	logic meas_edge; // Rising edge of the measurement clock.
	logic filt_edge; // Rising edge of the filter clock.
	logic lp_edge; // Rising edge of the reference clock.
	logic sysf_edge; // Rising edge of the system frequency clock.
	logic win_end; // Last reference edge of a window.
	logic setup_phase; // APB setup cycle.
	logic write_access; // APB write completes this cycle.
	logic addr_ok; // Address is a mapped aligned word.
	logic [31:0] read_word; // Read data selected by the address.
	logic [CSU_IRQ_W-1:0] irq_set; // Events of this cycle.
	logic [CSU_IRQ_W-1:0] irq_clr; // Write-one-to-clear bits of this cycle.
	logic [1:0] meas_flags; // New {high, low} of the measurement clock.
	logic [1:0] filt_flags; // New {high, low} of the filter clock.

	// Edges are taken from the second and third flops only.
	assign meas_edge = s.meas_sync[1] & ~s.meas_sync[2];
	assign filt_edge = s.filt_sync[1] & ~s.filt_sync[2];
	assign lp_edge = s.lp_sync[1] & ~s.lp_sync[2];
	assign sysf_edge = s.sysf_sync[1] & ~s.sysf_sync[2];
	assign win_end = lp_edge && (s.lp_cnt == WIN_LAST);
	assign setup_phase = apb_req_in.psel & ~apb_req_in.penable;
	assign write_access = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite & ~s.pslverr;

	// Address decode and read mux for the word-wide registers.
	always_comb begin
		addr_ok = 1'b1;
		read_word = 32'h0000_0000;
		case (apb_req_in.paddr)
			CSU_OFF_FREQ_STS: begin
				read_word[CSU_FS_MEAS_LSB +: CSU_FREQ_W] = s.meas_freq;
				read_word[CSU_FS_FILT_LSB +: CSU_FREQ_W] = s.filt_freq;
			end
			CSU_OFF_CTRL: begin
				read_word[0] = s.enable;
			end
			CSU_OFF_LIMITS: begin
				read_word = s.limits;
			end
			CSU_OFF_IRQ_STS: begin
				read_word[CSU_IRQ_W-1:0] = s.irq_sts;
			end
			CSU_OFF_IRQ_MASK: begin
				read_word[CSU_IRQ_W-1:0] = s.irq_mask;
			end
			CSU_OFF_CALIB: begin
				read_word[CSU_CAL_W-1:0] = s.calib;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// Next-state logic of measurement, flags, interrupts and registers.
	always_comb begin
		next_s = s;
		irq_set = '0;
		irq_clr = '0;
		meas_flags = {s.meas_high, s.meas_low};
		filt_flags = {s.filt_high, s.filt_low};

		// Two-flop synchronisers plus one flop for edge detection.
		next_s.meas_sync = {s.meas_sync[1:0], meas_clock_in};
		next_s.filt_sync = {s.filt_sync[1:0], filter_clock_in};
		next_s.lp_sync = {s.lp_sync[1:0], low_power_reference_clock_in};
		next_s.sysf_sync = {s.sysf_sync[1:0], system_freq_clock_in};

		// The window timer runs on the reference clock whether or not the watchdogs are enabled.
		if (lp_edge) begin
			next_s.lp_cnt = win_end ? '0 : s.lp_cnt + 1'b1;
		end

		// System clock loss: a whole window without a single edge; no software action needed.
		if (sysf_edge) begin
			next_s.sysf_seen = 1'b1;
		end
		if (win_end) begin
			next_s.sysf_seen = sysf_edge;
			next_s.clk_loss = ~(s.sysf_seen | sysf_edge);
			irq_set[CSU_IRQ_LOSS] = ~(s.sysf_seen | sysf_edge) & ~s.clk_loss;
		end

		if (!s.enable) begin
			// Powered down: counters idle, no frequency faults reported.
			next_s.meas_pre = '0;
			next_s.filt_pre = '0;
			next_s.meas_cnt = '0;
			next_s.filt_cnt = '0;
			next_s.meas_freq = '0;
			next_s.filt_freq = '0;
			next_s.meas_low = 1'b0;
			next_s.meas_high = 1'b0;
			next_s.filt_low = 1'b0;
			next_s.filt_high = 1'b0;
		end else begin
			// Measurement clock edge counting with prescaler and saturation.
			if (meas_edge) begin
				if (s.meas_pre == MEAS_LAST) begin
					next_s.meas_pre = '0;
					if (s.meas_cnt != FREQ_MAX) begin
						next_s.meas_cnt = s.meas_cnt + 1'b1;
					end
				end else begin
					next_s.meas_pre = s.meas_pre + 1'b1;
				end
			end
			// Filter clock edge counting, independent of the other watchdog.
			if (filt_edge) begin
				if (s.filt_pre == FILT_LAST) begin
					next_s.filt_pre = '0;
					if (s.filt_cnt != FREQ_MAX) begin
						next_s.filt_cnt = s.filt_cnt + 1'b1;
					end
				end else begin
					next_s.filt_pre = s.filt_pre + 1'b1;
				end
			end
			// At the end of a window publish the counts and judge them against the limits.
			if (win_end) begin
				meas_flags = csu_range(s.meas_cnt,
					s.limits[CSU_LIM_MEAS_UP +: CSU_FREQ_W], s.limits[CSU_LIM_MEAS_UP_HYS +: 2],
					s.limits[CSU_LIM_MEAS_LOW +: CSU_FREQ_W], s.limits[CSU_LIM_MEAS_LOW_HYS +: 2],
					s.meas_high, s.meas_low);
				filt_flags = csu_range(s.filt_cnt,
					s.limits[CSU_LIM_FILT_UP +: CSU_FREQ_W], s.limits[CSU_LIM_FILT_UP_HYS +: 2],
					s.limits[CSU_LIM_FILT_LOW +: CSU_FREQ_W], s.limits[CSU_LIM_FILT_LOW_HYS +: 2],
					s.filt_high, s.filt_low);
				next_s.meas_freq = s.meas_cnt;
				next_s.filt_freq = s.filt_cnt;
				next_s.meas_high = meas_flags[1];
				next_s.meas_low = meas_flags[0];
				next_s.filt_high = filt_flags[1];
				next_s.filt_low = filt_flags[0];
				next_s.meas_cnt = '0;
				next_s.filt_cnt = '0;
				next_s.meas_pre = '0;
				next_s.filt_pre = '0;
				irq_set[CSU_IRQ_MEAS] = (|meas_flags) & ~(s.meas_high | s.meas_low);
				irq_set[CSU_IRQ_FILT] = (|filt_flags) & ~(s.filt_high | s.filt_low);
			end
		end

		// Setup cycle: capture read data and judge the access for the access phase.
		if (setup_phase) begin
			next_s.prdata = addr_ok ? read_word : 32'h0000_0000;
			next_s.pslverr = ~addr_ok | (apb_req_in.pwrite & (apb_req_in.pstrb != CSU_FULL_WORD));
		end

		// Access phase of a good write updates the addressed register.
		if (write_access) begin
			case (apb_req_in.paddr)
				CSU_OFF_CTRL: begin
					next_s.enable = apb_req_in.pwdata[0];
				end
				CSU_OFF_LIMITS: begin
					next_s.limits = apb_req_in.pwdata;
				end
				CSU_OFF_IRQ_STS: begin
					irq_clr = apb_req_in.pwdata[CSU_IRQ_W-1:0];
				end
				CSU_OFF_IRQ_MASK: begin
					next_s.irq_mask = apb_req_in.pwdata[CSU_IRQ_W-1:0];
				end
				CSU_OFF_CALIB: begin
					next_s.calib = apb_req_in.pwdata[CSU_CAL_W-1:0];
				end
				default: begin
					next_s.calib = s.calib;
				end
			endcase
		end

		// Sticky events: a set in the same cycle as a clear wins.
		next_s.irq_sts = (s.irq_sts & ~irq_clr) | irq_set;
	end

	// State register; the clock enable freezes everything.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s <= STATE_RESET;
		end else if (clk_en_in) begin
			s <= next_s;
		end
	end

	// Outputs.
	assign apb_rsp_out.pready = apb_req_in.psel & apb_req_in.penable & clk_en_in;
	assign apb_rsp_out.prdata = s.prdata;
	assign apb_rsp_out.pslverr = s.pslverr;
	assign clock_fault_nmi_out = s.meas_low | s.meas_high | s.filt_low | s.filt_high;
	assign irq_out = |(s.irq_sts & s.irq_mask);
	assign shutdown_out.low_side_off = s.clk_loss;
	assign shutdown_out.high_side_off = s.clk_loss;
	assign shutdown_out.lin_off = s.clk_loss;
	assign tick_calibration_out = s.calib;

endmodule : csu_top
`default_nettype wire

// ===== verif/csu_monitor.sv
// Purpose: Port checker for the clock supervision unit.
// Assumes: One clock domain with an active high reset.
// Notes: Bound into csu_top after the module below.
`timescale 1ns/1ns
`default_nettype none
module csu_monitor
	import csu_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire csu_apb_req_type apb_req_in,
	input wire csu_apb_rsp_type apb_rsp_out,
	input wire logic clock_fault_nmi_out,
	input wire csu_shutdown_type shutdown_out,
	input wire logic [CSU_CAL_W-1:0] tick_calibration_out
);
	// Every property samples on the system clock and is off in reset.
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// Setup cycle of a register transfer.
	sequence s_setup;
		apb_req_in.psel && !apb_req_in.penable && clk_en_in;
	endsequence
	// Access cycle of a register transfer.
	sequence s_access;
		apb_req_in.psel && apb_req_in.penable && clk_en_in;
	endsequence
	// Whole transfer to one address in one direction.
	sequence s_xfer(logic [11:0] a, logic w);
		s_setup ##1 s_access ##0 (apb_req_in.paddr == a && apb_req_in.pwrite == w);
	endsequence
	AST_PREADY: assert property (s_access |-> apb_rsp_out.pready)
		else $error("pready missing in access cycle");
	AST_BAD_ADDR: assert property (s_xfer(12'h008, 1'b0) |-> apb_rsp_out.pslverr && apb_rsp_out.prdata == '0)
		else $error("unmapped read not refused");
	AST_BAD_STRB: assert property (s_setup ##1 s_access ##0 (apb_req_in.pwrite && apb_req_in.pstrb != 4'hf)
		|-> apb_rsp_out.pslverr) else $error("partial write not refused");
	AST_STS_READ: assert property (s_xfer(12'h000, 1'b0) |-> !apb_rsp_out.pslverr &&
		apb_rsp_out.prdata[31:14] == '0 && apb_rsp_out.prdata[7:6] == '0) else $error("status reserved bits set");
	AST_CTRL_READ: assert property (s_xfer(12'h004, 1'b0) |-> apb_rsp_out.prdata[31:1] == '0)
		else $error("control reserved bits set");
	AST_CAL_WRITE: assert property (s_xfer(12'h06c, 1'b1) ##0 apb_req_in.pstrb == 4'hf
		|=> tick_calibration_out == $past(apb_req_in.pwdata[25:0])) else $error("calibration write lost");
	AST_CAL_READ: assert property (s_xfer(12'h06c, 1'b0) |-> apb_rsp_out.prdata == {6'h00, tick_calibration_out})
		else $error("calibration read mismatch");
	AST_SHUT_SAME: assert property (shutdown_out.low_side_off == shutdown_out.high_side_off &&
		shutdown_out.high_side_off == shutdown_out.lin_off) else $error("shutdown lines differ");
	AST_DISABLE_NMI: assert property (s_xfer(12'h004, 1'b1) ##0 (apb_req_in.pstrb == 4'hf &&
		!apb_req_in.pwdata[0]) |-> ##2 !clock_fault_nmi_out) else $error("fault stays after disable");
endmodule : csu_monitor
bind csu_top csu_monitor u_csu_monitor (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
	.apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out), .clock_fault_nmi_out(clock_fault_nmi_out),
	.shutdown_out(shutdown_out), .tick_calibration_out(tick_calibration_out));
`default_nettype wire

// ===== verif/csu_clock_source.sv
// Purpose: Behavioural clock sources facing the supervision unit.
// Assumes: Half periods come in 10 ns steps and are never below 2.
// Notes: The system frequency clock stands still while its run input is low.
`timescale 1ns/1ns
`default_nettype none
module csu_clock_source #(
	parameter int REF_HALF = 40
) (
	input wire logic [7:0] meas_half_in,
	input wire logic [7:0] filt_half_in,
	input wire logic sys_run_in,
	output logic meas_clk_out,
	output logic filt_clk_out,
	output logic ref_clk_out,
	output logic sys_freq_clk_out
);
	// All clocks start low.
	initial begin
		meas_clk_out = 1'b0;
		filt_clk_out = 1'b0;
		ref_clk_out = 1'b0;
		sys_freq_clk_out = 1'b0;
	end
	// The reference runs free, apart from the clocks it times.
	always #(REF_HALF * 10) ref_clk_out = ~ref_clk_out;
	// Monitored clocks follow the half periods the bench sets.
	always begin
		#(int'(meas_half_in) * 10);
		meas_clk_out = ~meas_clk_out;
	end
	always begin
		#(int'(filt_half_in) * 10);
		filt_clk_out = ~filt_clk_out;
	end
	// The system frequency clock freezes to model a lost clock.
	always begin
		#50;
		if (sys_run_in) begin
			sys_freq_clk_out = ~sys_freq_clk_out;
		end
	end
endmodule : csu_clock_source
`default_nettype wire

// ===== verif/csu_top_tb.sv
// Purpose: Self-checking bench of the clock supervision unit.
// Assumes: A window of 4 reference periods of 800 ns, so 320 system clocks.
// Notes: Frequency fields may be one count off through sampling jitter.
`timescale 1ns/1ns
`default_nettype none
module csu_top_tb
	import csu_pkg::*;
;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic clk_en_in = 1'b1;
	csu_apb_req_type req = '0;
	csu_apb_rsp_type rsp;
	logic [7:0] mh = 8'h05;
	logic [7:0] fh = 8'h07;
	logic run = 1'b1;
	logic mc, fc, rc, sc, nmi, irq, err;
	csu_shutdown_type shut;
	logic [25:0] tick;
	logic [31:0] rd;
	int errors = 0;
	int tests_run = 0;
	// Free running 100 MHz system clock.
	always #5 sys_clk_in = ~sys_clk_in;
	csu_clock_source u_csu_clock_source (.meas_half_in(mh), .filt_half_in(fh), .sys_run_in(run),
		.meas_clk_out(mc), .filt_clk_out(fc), .ref_clk_out(rc), .sys_freq_clk_out(sc));
	csu_top #(.LP_WINDOW(4)) u_csu_top (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
		.apb_req_in(req), .apb_rsp_out(rsp), .meas_clock_in(mc), .filter_clock_in(fc),
		.low_power_reference_clock_in(rc), .system_freq_clock_in(sc), .clock_fault_nmi_out(nmi),
		.irq_out(irq), .shutdown_out(shut), .tick_calibration_out(tick));
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : check
	task automatic near(input string n, input logic [5:0] e, input logic [5:0] g);
		tests_run++;
		if (!(g === e || g === e + 6'h01 || g === e - 6'h01)) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : near
	// One register transfer; holds the request until pready is seen or 16 access cycles pass.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
		@(posedge sys_clk_in);
		req.penable <= 1'b1;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (rsp.pready !== 1'b1 && n < 16);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		check("pready", 32'h1, {31'h0, rsp.pready});
	endtask : apb
	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0, 4'hf);
		check(n, e, rd);
		check("pslverr", {31'h0, ee}, {31'h0, err});
	endtask : rchk
	task automatic wait_win();
		repeat (980) @(posedge sys_clk_in);
	endtask : wait_win
	task automatic t_regs();
		rchk("ctrl", CSU_OFF_CTRL, 32'h0000_0001, 1'b0);
		rchk("limits", CSU_OFF_LIMITS, 32'hd4e1_94b3, 1'b0);
		rchk("calib", CSU_OFF_CALIB, 32'h0000_0000, 1'b0);
		apb(1'b1, CSU_OFF_CALIB, 32'hffff_ffff, 4'hf);
		rchk("calib", CSU_OFF_CALIB, 32'h03ff_ffff, 1'b0);
		apb(1'b1, CSU_OFF_CALIB, 32'h0000_0000, 4'h3);
		check("partial write", 32'h1, {31'h0, err});
		rchk("calib", CSU_OFF_CALIB, 32'h03ff_ffff, 1'b0);
		apb(1'b1, CSU_OFF_CALIB, 32'h030f_423f, 4'hf);
		@(negedge sys_clk_in);
		check("tick", 32'h030f_423f, {6'h00, tick});
		rchk("unmapped", 12'h008, 32'h0000_0000, 1'b1);
		rchk("misaligned", 12'h005, 32'h0000_0000, 1'b1);
		$display("test registers done");
	endtask : t_regs
	task automatic t_meas();
		wait_win();
		apb(1'b0, CSU_OFF_FREQ_STS, 32'h0, 4'hf);
		near("meas freq", 6'd32, rd[5:0]);
		near("filter freq", 6'd23, rd[13:8]);
		check("nmi", 32'h0, {31'h0, nmi});
		$display("test measure done");
	endtask : t_meas
	task automatic t_range();
		apb(1'b1, CSU_OFF_LIMITS, 32'h003f_df3f, 4'hf);
		mh <= 8'd20;
		wait_win();
		check("nmi low", 32'h1, {31'h0, nmi});
		mh <= 8'd5;
		wait_win();
		check("nmi hysteresis", 32'h1, {31'h0, nmi});
		apb(1'b1, CSU_OFF_LIMITS, 32'h003f_dc3f, 4'hf);
		wait_win();
		check("nmi cleared", 32'h0, {31'h0, nmi});
		apb(1'b1, CSU_OFF_LIMITS, 32'h000a_dc3f, 4'hf);
		wait_win();
		check("nmi high", 32'h1, {31'h0, nmi});
		rchk("irq status", CSU_OFF_IRQ_STS, 32'h0000_0003, 1'b0);
		check("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, CSU_OFF_IRQ_MASK, 32'h0000_0002, 4'hf);
		@(negedge sys_clk_in);
		check("irq", 32'h1, {31'h0, irq});
		apb(1'b1, CSU_OFF_IRQ_STS, 32'h0000_0003, 4'hf);
		@(negedge sys_clk_in);
		check("irq cleared", 32'h0, {31'h0, irq});
		apb(1'b1, CSU_OFF_CTRL, 32'h0000_0000, 4'hf);
		repeat (3) @(negedge sys_clk_in);
		check("nmi off", 32'h0, {31'h0, nmi});
		rchk("status off", CSU_OFF_FREQ_STS, 32'h0, 1'b0);
		apb(1'b1, CSU_OFF_CTRL, 32'h0000_0001, 4'hf);
		apb(1'b1, CSU_OFF_LIMITS, 32'hd4e1_94b3, 4'hf);
		$display("test range done");
	endtask : t_range
	task automatic t_loss();
		apb(1'b1, CSU_OFF_IRQ_MASK, 32'h0000_0004, 4'hf);
		run <= 1'b0;
		wait_win();
		check("shutdown", 32'h7, {29'h0, shut});
		check("irq loss", 32'h1, {31'h0, irq});
		apb(1'b0, CSU_OFF_IRQ_STS, 32'h0, 4'hf);
		check("loss status", 32'h4, rd & 32'h4);
		run <= 1'b1;
		wait_win();
		check("shutdown off", 32'h0, {29'h0, shut});
		$display("test loss done");
	endtask : t_loss
	task automatic results();
		$display("tests %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results
	// Main sequence after a three cycle reset.
	initial begin
		repeat (3) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		check("nmi reset", 32'h0, {31'h0, nmi});
		t_regs();
		t_meas();
		t_range();
		t_loss();
		results();
	end
	// Watchdog cuts a hang short.
	initial begin
		#500000;
		errors++;
		results();
	end
endmodule : csu_top_tb
`default_nettype wire
